// *** buck_seq_pkg.sv ***
// Package of constants and types for the converter enable sequencer
package buck_seq_pkg;

   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ            = 250;
   localparam int MIN_OFF_TIME_NS    = 150;
   localparam int DUTY_WINDOW_US     = 12;
   localparam int SOFT_START_MS      = 4;
   localparam int OV_DISABLE_US      = 3;
   localparam int HOLDOFF_US         = 100;
   // Least times round up, longest round down
   localparam int MIN_OFF_CYCLES     = (MIN_OFF_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int DUTY_WINDOW_CYCLES = DUTY_WINDOW_US * CLK_MHZ;
   localparam int SOFT_START_CYCLES  = SOFT_START_MS * 1000 * CLK_MHZ;
   localparam int OV_DISABLE_CYCLES  = OV_DISABLE_US * CLK_MHZ;
   localparam int HOLDOFF_CYCLES     = HOLDOFF_US * CLK_MHZ;

   // -----------------------------------------------------------------
   // Output voltage select and soft-start code
   // -----------------------------------------------------------------
   localparam int          VSEL_W       = 3;
   localparam logic [2:0]  VSEL_RESET   = 3'h2;
   localparam int          RAMP_W       = 10;
   localparam logic [9:0]  RAMP_FULL    = 10'h3FF;

   // -----------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b000,
      ST_WAIT_EN = 3'b001,
      ST_HOLDOFF = 3'b010,
      ST_RAMP    = 3'b011,
      ST_RUN     = 3'b100,
      ST_OV_OFF  = 3'b101
   } seq_state_t;

endpackage

// *** seq_timer_if.sv ***
// Interface between the sequencer and its down-counting timer
`timescale 1ns/1ps
interface seq_timer_if #(parameter int W = 24);
   logic         load;
   logic [W-1:0] value;
   logic         done;
   modport ctrl (output load, output value, input done);
   modport tmr  (input load, input value, output done);
endinterface

// *** seq_timer.sv ***
// Loadable down counter with a registered expiry flag
`timescale 1ns/1ps
module seq_timer #(parameter int W = 24)
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Control
   seq_timer_if.tmr  t
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         done_reg;
   logic         done_next;

   always_comb
   begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (t.load)
      begin
         cnt_next = t.value;
      end
      else if (cnt_reg != '0)
      begin
         cnt_next  = cnt_reg - 1'b1;
         done_next = (cnt_reg == W'(1));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign t.done = done_reg;
endmodule

// *** buck_enable_sequencer.sv ***
// Enable, start-up and restart sequencing for the step-down converter
// Notes on behaviour
// [RULE_01] - Low system enable without hold: regulators off, standby
// [RULE_02] - Converter runs while converter enable pin high
// [RULE_03] - Low pin overrides register enable command
// [RULE_04] - Pin low at system enable rise: wait
// [RULE_05] - Clamp overvoltage opens USB data switches
// [RULE_06] - Logic regulator starts: system enable and supply ok
// [RULE_07] - Logic undervoltage holds all control disabled; fixed_freq_mode is not gated by it
// [RULE_08] - Persistent minimum off-time forces periodic low-side pulse
// [RULE_09] - Three-bit output voltage select, default 5.1V
// [RULE_10] - Soft-start ramp to 5.15V over 4ms
// [RULE_11] - Disable discharges output sense, except overvoltage
// [RULE_12] - Discharge starts hold-off; no restart until expiry
// [RULE_13] - No enforced power-up order among enables, clamp
// [RULE_14] - Host should raise clamp supply before enable
// [RULE_15] - Host holds clamp supply for USB data
// [RULE_16] - Current limit; skip moves to fixed frequency
// [RULE_17] - Dropout: high duty mode, capped near 98%
// [RULE_18] - Sense overvoltage: off after 3us, restart, no discharge
// [RULE_19] - Charger profile change resets converter
// [RULE_20] - Hold-off time and hold mode are parameters
`timescale 1ns/1ps
module buck_enable_sequencer
   import buck_seq_pkg::*;
#(
   parameter int  HOLDOFF_CNT  = buck_seq_pkg::HOLDOFF_CYCLES,
   parameter int  SOFT_CNT     = buck_seq_pkg::SOFT_START_CYCLES,
   parameter int  WINDOW_CNT   = buck_seq_pkg::DUTY_WINDOW_CYCLES,
   parameter bit  HOLD_MODE    = 1'b0
)
(
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_b,
   // Enables and supply comparators (asynchronous)
   input  wire logic                     system_enable_pin,
   input  wire logic                     converter_enable_pin,
   input  wire logic                     reg_enable,
   input  wire logic                     switch_supply_ok,
   input  wire logic                     logic_uv,
   input  wire logic                     clamp_ov,
   input  wire logic                     sense_ov,
   input  wire logic                     charger_profile_select,
   input  wire logic                     charger_profile_bit,
   // Cycle monitor (asynchronous)
   input  wire logic                     min_off_cycle,
   input  wire logic                     current_limit,
   input  wire logic                     load_present,
   input  wire logic                     output_low,
   // Configuration
   input  wire logic [buck_seq_pkg::VSEL_W-1:0] vsel_in,
   input  wire logic                     vsel_write,
   // Outputs
   output logic                          regulators_on,
   output logic                          standby,
   output logic                          control_enable,
   output logic                          converter_run,
   output logic                          data_switch_closed,
   output logic                          discharge_on,
   output logic                          low_side_force,
   output logic                          high_side_block,
   output logic                          fixed_freq_mode,
   output logic                          high_duty_mode,
   output logic [buck_seq_pkg::VSEL_W-1:0] output_voltage_select,
   output logic [buck_seq_pkg::RAMP_W-1:0] soft_start_level,
   output logic [2:0]                    seq_state
);
   import buck_seq_pkg::*;

   // Timer width follows the ramp count, so the shorter loads must fit in it
   if (HOLDOFF_CNT < 1 || SOFT_CNT <= int'(RAMP_FULL) || WINDOW_CNT <= MIN_OFF_CYCLES ||
       HOLDOFF_CNT > SOFT_CNT || OV_DISABLE_CYCLES > SOFT_CNT)
   begin : g_bad_timing
      $error("buck_enable_sequencer: bad timing parameter");
   end

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NS = 13;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   // Enables and clamp accepted in any arrival order [RULE_13]
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= {system_enable_pin, converter_enable_pin, reg_enable,
                    switch_supply_ok, logic_uv, clamp_ov, sense_ov,
                    charger_profile_select, charger_profile_bit,
                    min_off_cycle, current_limit, load_present, output_low};
         s2_reg <= s1_reg;
      end
   end
   logic sen, cen, ren, sok, luv, cov, sov, cps, cpb, moff, ilim, ldp, olow;
   assign {sen, cen, ren, sok, luv, cov, sov, cps, cpb, moff, ilim, ldp, olow} = s2_reg;

   // -----------------------------------------------------------------
   // Timer shared by hold-off and overvoltage delay
   // -----------------------------------------------------------------
   localparam int TW = $clog2(SOFT_CNT + 1);
   seq_timer_if #(.W(TW)) tif ();
   seq_timer #(.W(TW)) u_timer
   (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .t       (tif.tmr)
   );

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   seq_state_t       st_reg, st_next;
   logic             sen_d_reg, sen_d_next;
   logic             arm_reg, arm_next;
   logic             prof_reg, prof_next;
   logic             dis_reg, dis_next;
   logic [RAMP_W-1:0] ramp_reg, ramp_next;
   logic [TW-1:0]    step_reg, step_next;
   logic [VSEL_W-1:0] vsel_reg, vsel_next;
   logic             reg_on, ctl_on, want, prof_chg;
   localparam logic [TW-1:0] STEP = TW'(SOFT_CNT / 1024);

   always_comb
   begin
      reg_on   = sen || HOLD_MODE;                                  // [RULE_01] [RULE_20]
      ctl_on   = reg_on && sok && !luv;                             // [RULE_06] [RULE_07]
      want     = cen && ren && arm_reg;                             // [RULE_02] [RULE_03]
      st_next    = st_reg;
      sen_d_next = sen;
      arm_next   = arm_reg;
      prof_next  = cps ^ cpb;
      dis_next   = dis_reg;
      ramp_next  = ramp_reg;
      step_next  = step_reg;
      vsel_next  = vsel_write ? vsel_in : vsel_reg;                 // [RULE_09]
      tif.load   = 1'b0;
      tif.value  = '0;
      prof_chg   = (cps ^ cpb) != prof_reg;
      if (sen && !sen_d_reg && !cen)
         arm_next = 1'b0;                                           // [RULE_04]
      else if (cen)
         arm_next = 1'b1;
      if (!ctl_on)
      begin
         st_next   = reg_on ? ST_WAIT_EN : ST_STANDBY;
         dis_next  = 1'b0;
         ramp_next = '0;
      end
      else
      begin
         unique case (st_reg)
            ST_STANDBY, ST_WAIT_EN:
            begin
               if (want)
               begin
                  st_next   = ST_RAMP;
                  step_next = STEP;
                  ramp_next = '0;
               end
            end
            ST_HOLDOFF:
            begin
               if (tif.done)                                        // [RULE_12]
               begin
                  dis_next = 1'b0;
                  st_next  = ST_WAIT_EN;
               end
            end
            ST_RAMP, ST_RUN:
            begin
               if (!want || prof_chg)                               // [RULE_11] [RULE_19]
               begin
                  st_next   = ST_HOLDOFF;
                  dis_next  = 1'b1;
                  ramp_next = '0;
                  tif.load  = 1'b1;
                  tif.value = TW'(HOLDOFF_CNT);                     // [RULE_12]
               end
               else if (sov)
               begin
                  st_next   = ST_OV_OFF;
                  tif.load  = 1'b1;
                  tif.value = TW'(OV_DISABLE_CYCLES);               // [RULE_18]
               end
               else if (st_reg == ST_RAMP)
               begin
                  step_next = step_reg - 1'b1;                      // [RULE_10]
                  if (step_reg == TW'(1))
                  begin
                     step_next = STEP;
                     ramp_next = ramp_reg + 1'b1;
                     if (ramp_reg == RAMP_FULL - 1'b1)
                        st_next = ST_RUN;
                  end
               end
            end
            ST_OV_OFF:
            begin
               // Once really stopped, the restart soft-starts from zero
               if (tif.done)
                  ramp_next = '0;                                   // [RULE_10]
               if (!sov)
               begin
                  step_next = STEP;
                  st_next   = (ramp_reg == RAMP_FULL && !tif.done) ?
                              ST_RUN : ST_RAMP;                     // [RULE_18]
               end
               if (!want)
               begin
                  st_next   = ST_HOLDOFF;
                  dis_next  = 1'b1;
                  tif.load  = 1'b1;
                  tif.value = TW'(HOLDOFF_CNT);
               end
            end
            default:
               st_next = ST_STANDBY;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg    <= ST_STANDBY;
         sen_d_reg <= 1'b0;
         arm_reg   <= 1'b1;
         prof_reg  <= 1'b0;
         dis_reg   <= 1'b0;
         ramp_reg  <= '0;
         step_reg  <= '0;
         vsel_reg  <= VSEL_RESET;
      end
      else
      begin
         st_reg    <= st_next;
         sen_d_reg <= sen_d_next;
         arm_reg   <= arm_next;
         prof_reg  <= prof_next;
         dis_reg   <= dis_next;
         ramp_reg  <= ramp_next;
         step_reg  <= step_next;
         vsel_reg  <= vsel_next;
      end
   end

   // -----------------------------------------------------------------
   // Maximum duty monitor
   // -----------------------------------------------------------------
   localparam int WW = $clog2(WINDOW_CNT + 1);
   logic [WW-1:0] win_reg, win_next;
   logic [7:0]    pulse_reg, pulse_next;
   logic          running;
   logic          ovoff_reg;
   assign running = (st_reg == ST_RUN) || (st_reg == ST_RAMP) ||
                    (st_reg == ST_OV_OFF && !ovoff_reg && !tif.done);

   always_comb
   begin
      win_next   = win_reg;
      pulse_next = (pulse_reg != '0) ? pulse_reg - 1'b1 : pulse_reg;
      if (!running || !moff)
         win_next = '0;                                             // [RULE_08]
      else if (win_reg == WW'(WINDOW_CNT - 1))
      begin
         win_next   = '0;
         pulse_next = 8'(MIN_OFF_CYCLES);                           // [RULE_08]
      end
      else
         win_next = win_reg + 1'b1;
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         win_reg   <= '0;
         pulse_reg <= '0;
         ovoff_reg <= 1'b0;
         regulators_on         <= 1'b0;
         standby               <= 1'b1;
         control_enable        <= 1'b0;
         converter_run         <= 1'b0;
         data_switch_closed    <= 1'b0;
         discharge_on          <= 1'b0;
         low_side_force        <= 1'b0;
         high_side_block       <= 1'b0;
         fixed_freq_mode       <= 1'b0;
         high_duty_mode        <= 1'b0;
         output_voltage_select <= VSEL_RESET;
         soft_start_level      <= '0;
         seq_state             <= '0;
      end
      else
      begin
         win_reg   <= win_next;
         pulse_reg <= pulse_next;
         ovoff_reg <= (st_reg == ST_OV_OFF) && tif.done ? 1'b1 :
                      (st_reg == ST_OV_OFF) ? ovoff_reg : 1'b0;
         regulators_on      <= reg_on;                              // [RULE_01] [RULE_06]
         standby            <= !reg_on;                             // [RULE_01]
         control_enable     <= ctl_on;                              // [RULE_07]
         // Gated by control so it drops with standby, not a cycle later
         converter_run      <= running && ctl_on;                   // [RULE_02] [RULE_18]
         data_switch_closed <= ctl_on && !cov;                      // [RULE_05]
         discharge_on       <= dis_reg;                             // [RULE_11]
         low_side_force     <= pulse_next != '0;                    // [RULE_08] [RULE_17]
         high_side_block    <= ilim && running;                     // [RULE_16]
         fixed_freq_mode    <= ldp || ilim;                         // [RULE_16]
         high_duty_mode     <= running && olow;                     // [RULE_17]
         output_voltage_select <= vsel_reg;
         soft_start_level   <= (st_reg == ST_RUN) ? RAMP_FULL : ramp_reg; // [RULE_10]
         seq_state          <= st_reg;
      end
   end
endmodule

// *** buck_enable_sequencer_monitor.sv ***
// Checker of enable, restart and pulse relations at the sequencer ports
`timescale 1ns/1ps
module buck_enable_sequencer_monitor
#(
   parameter int HOLDOFF_CNT = 200
)
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // Watched inputs
   input wire logic       system_enable_pin,
   input wire logic       converter_enable_pin,
   input wire logic       reg_enable,
   input wire logic       logic_uv,
   input wire logic       clamp_ov,
   // Watched outputs
   input wire logic       regulators_on,
   input wire logic       standby,
   input wire logic       control_enable,
   input wire logic       converter_run,
   input wire logic       data_switch_closed,
   input wire logic       discharge_on,
   input wire logic       low_side_force,
   input wire logic [2:0] output_voltage_select,
   input wire logic [9:0] soft_start_level,
   input wire logic [2:0] seq_state
);
   // -----------------------------------------------------------------
   // Run-length counters
   // -----------------------------------------------------------------
   logic [15:0] dis_reg;
   logic [15:0] dis_next;
   logic [15:0] ls_reg;
   logic [15:0] ls_next;

   always_comb
   begin
      dis_next = discharge_on ? dis_reg + 16'h0001 : 16'h0000;
      ls_next  = low_side_force ? ls_reg + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dis_reg <= 16'h0000;
         ls_reg  <= 16'h0000;
      end
      else
      begin
         dis_reg <= dis_next;
         ls_reg  <= ls_next;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   a_standby_all_off: assert property (standby |-> !regulators_on && !converter_run)
      else $error("converter or regulators on in standby");
   a_pin_low_stops: assert property ((!converter_enable_pin) [*5] |-> !converter_run)
      else $error("converter runs with its pin low");
   a_reg_low_stops: assert property ((!reg_enable) [*5] |-> !converter_run)
      else $error("converter runs with register enable low");
   a_clamp_opens_switch: assert property (clamp_ov [*5] |-> !data_switch_closed)
      else $error("data switches closed during clamp overvoltage");
   a_uv_holds_control: assert property (logic_uv [*5] |-> !control_enable)
      else $error("control enabled under logic undervoltage");
   a_pulse_width_ok: assert property ($fell(low_side_force) && converter_run
      |-> ls_reg >= 16'h0025 && ls_reg <= 16'h0027)
      else $error("low-side pulse width wrong");
   a_vsel_after_reset: assert property ($rose(rst_b) |-> output_voltage_select == 3'h2)
      else $error("voltage select not at default after reset");
   a_ramp_starts_low: assert property ($rose(converter_run) |-> soft_start_level < 10'h010)
      else $error("soft-start level not low at enable");
   a_discharge_no_run: assert property (discharge_on |-> !converter_run)
      else $error("converter runs while discharging");
   a_holdoff_full: assert property ($fell(discharge_on) && system_enable_pin && !logic_uv
      |-> dis_reg >= HOLDOFF_CNT - 2)
      else $error("hold-off ended early");
   a_ov_no_discharge: assert property (seq_state == 3'h5 |-> !discharge_on)
      else $error("discharge during sense overvoltage");
endmodule

bind buck_enable_sequencer buck_enable_sequencer_monitor #(.HOLDOFF_CNT(HOLDOFF_CNT)) mon
(
   .clk_sys, .rst_b, .system_enable_pin, .converter_enable_pin, .reg_enable, .logic_uv,
   .clamp_ov, .regulators_on, .standby, .control_enable, .converter_run, .data_switch_closed,
   .discharge_on, .low_side_force, .output_voltage_select, .soft_start_level, .seq_state
);

// *** host_enable_model.sv ***
// Host model driving the system enable, converter enable and clamp supply
`timescale 1ns/1ps
module host_enable_model
(
   // Clock
   input wire logic clk_sys,
   // Driven pins
   output logic     system_enable_pin,
   output logic     converter_enable_pin,
   output logic     reg_enable,
   output logic     clamp_ov
);
   // Clamp supply in range before enable; set_pins can later raise clamp_ov
   initial
   begin
      clamp_ov             = 1'b0;
      system_enable_pin    = 1'b0;
      converter_enable_pin = 1'b0;
      reg_enable           = 1'b0;
   end

   // All four pins change together on one falling clock edge, to the levels the caller picks
   task automatic set_pins(input logic s, input logic c, input logic r, input logic k);
      @(negedge clk_sys);
      system_enable_pin    = s;
      converter_enable_pin = c;
      reg_enable           = r;
      clamp_ov             = k;
   endtask
endmodule

// *** buck_enable_sequencer_tb.sv ***
// Self-checking testbench for the converter enable sequencer
`timescale 1ns/1ps
module buck_enable_sequencer_tb;
   import buck_seq_pkg::*;
   localparam int HOLD = 200;
   localparam int SOFT = 2048;
   localparam int WIN  = 100;

   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic system_enable_pin, converter_enable_pin, reg_enable, clamp_ov;
   logic switch_supply_ok = 1'b0, logic_uv = 1'b0, sense_ov = 1'b0;
   logic charger_profile_select = 1'b0, charger_profile_bit = 1'b0;
   logic min_off_cycle = 1'b0, current_limit = 1'b0, load_present = 1'b0, output_low = 1'b0;
   logic [2:0] vsel_in = 3'h0;
   logic vsel_write = 1'b0;
   logic regulators_on, standby, control_enable, converter_run, data_switch_closed;
   logic discharge_on, low_side_force, high_side_block, fixed_freq_mode, high_duty_mode;
   logic [2:0] output_voltage_select, seq_state;
   logic [9:0] soft_start_level;
   int error_cnt = 0;
   int check_count = 0;
   int cyc_cnt = 0;

   always #2 clk_sys = ~clk_sys;

   host_enable_model h (.clk_sys, .system_enable_pin, .converter_enable_pin, .reg_enable,
      .clamp_ov);

   buck_enable_sequencer #(.HOLDOFF_CNT(HOLD), .SOFT_CNT(SOFT), .WINDOW_CNT(WIN)) dut
   (
      .clk_sys, .rst_b, .system_enable_pin, .converter_enable_pin, .reg_enable,
      .switch_supply_ok, .logic_uv, .clamp_ov, .sense_ov, .charger_profile_select,
      .charger_profile_bit, .min_off_cycle, .current_limit, .load_present, .output_low,
      .vsel_in, .vsel_write, .regulators_on, .standby, .control_enable, .converter_run,
      .data_switch_closed, .discharge_on, .low_side_force, .high_side_block,
      .fixed_freq_mode, .high_duty_mode, .output_voltage_select, .soft_start_level,
      .seq_state
   );

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Ceiling well above the few thousand cycles the sequence needs
   always @(posedge clk_sys)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_power_up();
      chk(standby, 1'h1);
      chk(output_voltage_select, VSEL_RESET);
      h.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
      switch_supply_ok = 1'b1;
      cyc(40);
      chk(regulators_on, 1'h1);
      chk(control_enable, 1'h1);
      chk(converter_run, 1'h0);
      h.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      cyc(10);
      chk(converter_run, 1'h1);
      chk(seq_state, 3'h3);
      cyc(SOFT + 40);
      chk(soft_start_level, RAMP_FULL);
      chk(seq_state, 3'h4);
   endtask

   task automatic t_drive_modes();
      current_limit = 1'b1;
      output_low = 1'b1;
      load_present = 1'b1;
      cyc(10);
      chk(high_side_block, 1'h1);
      chk(high_duty_mode, 1'h1);
      chk(fixed_freq_mode, 1'h1);
      current_limit = 1'b0;
      output_low = 1'b0;
      load_present = 1'b0;
      cyc(10);
      chk(high_side_block, 1'h0);
      chk(high_duty_mode, 1'h0);
      chk(fixed_freq_mode, 1'h0);
   endtask

   task automatic t_low_side();
      int n;
      n = 0;
      min_off_cycle = 1'b1;
      while (low_side_force !== 1'b1 && n < 3 * WIN)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(n >= WIN - 2 && n <= WIN + 10, 1'h1);
      // Released after the pulse, before the window can fire another one
      cyc(45);
      min_off_cycle = 1'b0;
      cyc(10);
   endtask

   task automatic t_clamp();
      chk(data_switch_closed, 1'h1);
      h.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
      cyc(10);
      chk(data_switch_closed, 1'h0);
      chk(converter_run, 1'h1);
      h.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      cyc(10);
      chk(data_switch_closed, 1'h1);
   endtask

   task automatic t_sense_ov();
      sense_ov = 1'b1;
      cyc(20);
      chk(converter_run, 1'h1);
      cyc(OV_DISABLE_CYCLES + 20);
      chk(converter_run, 1'h0);
      chk(discharge_on, 1'h0);
      sense_ov = 1'b0;
      cyc(10);
      chk(converter_run, 1'h1);
   endtask

   task automatic t_holdoff();
      h.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
      cyc(10);
      chk(converter_run, 1'h0);
      chk(discharge_on, 1'h1);
      h.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      cyc(HOLD / 2);
      chk(converter_run, 1'h0);
      chk(seq_state, 3'h2);
      cyc(HOLD);
      chk(converter_run, 1'h1);
      chk(discharge_on, 1'h0);
   endtask

   task automatic t_profile();
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
            charger_profile_bit = 1'b1;
         else
            charger_profile_select = 1'b1;
         cyc(10);
         chk(discharge_on, 1'h1);
         chk(converter_run, 1'h0);
         cyc(HOLD + 20);
         chk(converter_run, 1'h1);
      end
   endtask

   task automatic t_vsel_uv_off();
      vsel_in = 3'h5;
      vsel_write = 1'b1;
      cyc(1);
      vsel_write = 1'b0;
      cyc(2);
      chk(output_voltage_select, 3'h5);
      logic_uv = 1'b1;
      cyc(10);
      chk(control_enable, 1'h0);
      chk(converter_run, 1'h0);
      logic_uv = 1'b0;
      cyc(10);
      chk(control_enable, 1'h1);
      h.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
      cyc(10);
      chk(standby, 1'h1);
      chk(regulators_on, 1'h0);
   endtask

   initial
   begin
      cyc(5);
      rst_b = 1'b1;
      cyc(2);
      t_power_up();
      t_drive_modes();
      t_low_side();
      t_clamp();
      t_sense_ov();
      cyc(SOFT + 40);
      t_holdoff();
      t_profile();
      t_vsel_uv_off();
      conclude();
   end
endmodule
